// ---- inc/rrc_pkg.sv ----
// constants and types for the relay-remote command decoder
package rrc_pkg;
  localparam int CLK_HZ = 25000000;
  localparam int DEBOUNCE_MS = 100;
  localparam int GAP_MS = 10000;
  localparam int WD_MS = 1000;
  localparam int DEBOUNCE_CYC = CLK_HZ / 1000 * DEBOUNCE_MS;
  localparam int GAP_CYC = CLK_HZ / 1000 * GAP_MS;
  localparam int WD_CYC = CLK_HZ / 1000 * WD_MS;
  localparam int CNT_W = 28;
  localparam int LINES = 4;
  // change patterns, bit 3 down to bit 0
  localparam logic [3:0] PAT_START = 4'hf;
  localparam logic [3:0] PAT_EXEC = 4'hc;
  localparam logic [3:0] PAT_AUTO = 4'h2;
  localparam logic [3:0] PAT_REMOTE = 4'h1;
  localparam logic [3:0] PAT_BMOD = 4'hd;
  localparam logic [3:0] PAT_BDEMOD = 4'h9;
  localparam logic [3:0] PAT_TGT1 = 4'h1;
  localparam logic [3:0] PAT_TGT2 = 4'h2;
  localparam logic [3:0] PAT_TGT3 = 4'h3;
  localparam logic [3:0] PAT_TGT4 = 4'h4;
  localparam logic [3:0] LINES_IDLE = 4'hf;
  // register byte offsets
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_COUNT = 8'h08;
  // status fields
  localparam int ST_REMOTE = 0;
  localparam int ST_SEQ = 1;
  localparam int ST_LINES = 4;
  localparam int ST_MOD = 8;
  localparam int ST_DMD = 12;
  localparam int ST_LAST = 16;
  localparam int ST_CTRL_OK = 20;
  // control fields
  localparam int CT_KICK = 0;
  typedef enum logic [1:0] {SQ_IDLE, SQ_CMD, SQ_TGT, SQ_EXE} rrc_seq_e;
  typedef enum logic [1:0] {CM_AUTO, CM_REMOTE, CM_BMOD, CM_BDEMOD} rrc_cmd_e;
endpackage

// ---- rtl/rrc_decoder.sv ----
// relay-remote command decoder with fault and online-status relays
`timescale 1ns/10ps
`default_nettype none
module rrc_decoder #(
  parameter int DEBOUNCE_CYC = rrc_pkg::DEBOUNCE_CYC,
  parameter int GAP_CYC = rrc_pkg::GAP_CYC,
  parameter int WD_CYC = rrc_pkg::WD_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cmd_input_bit3_i,
  input wire logic cmd_input_bit2_i,
  input wire logic cmd_input_bit1_i,
  input wire logic cmd_input_bit0_i,
  input wire logic backup_fail_i,
  input wire logic comm_fail_i,
  input wire logic config_fail_i,
  input wire logic setup_fail_i,
  input wire logic [3:0] dmd_active_i,
  input wire logic [3:0] dmd_carrier_loss_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic ctrl_fault_relay_o,
  output logic sys_fault_relay_o,
  output logic dmd_sig_fault_relay_o,
  output logic [3:0] mod_online_relay_o,
  output logic [3:0] dmd_online_relay_o,
  output logic remote_mode_o
);
  localparam int CW = rrc_pkg::CNT_W;

  if (DEBOUNCE_CYC < 1 || DEBOUNCE_CYC >= 2 ** CW) begin : g_chk_deb
    $error("debounce count out of range");
  end
  if (GAP_CYC < 1 || GAP_CYC >= 2 ** CW) begin : g_chk_gap
    $error("gap count out of range");
  end
  if (WD_CYC < 1 || WD_CYC >= 2 ** CW) begin : g_chk_wd
    $error("monostable count out of range");
  end

  localparam logic [CW-1:0] DEB_LAST = CW'(DEBOUNCE_CYC - 1);
  localparam logic [CW-1:0] GAP_LAST = CW'(GAP_CYC - 1);
  localparam logic [CW-1:0] WD_LOAD = CW'(WD_CYC);

  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;
    logic [3:0] acc;
    logic [3:0] pend;
    logic [CW-1:0] deb_cnt;
    logic word_ev;
    logic [3:0] word_pat;
    logic [3:0] last_pat;
    rrc_pkg::rrc_seq_e seq;
    rrc_pkg::rrc_cmd_e cmd;
    logic [3:0] tgt;
    logic [CW-1:0] gap_cnt;
    logic remote;
    logic [3:0] mod_on;
    logic [3:0] dmd_on;
    logic [CW-1:0] wd_cnt;
    logic sys_rel;
    logic dsf_rel;
    logic ack;
    logic [31:0] rdat;
    logic [7:0] exec_cnt;
  } rrc_state_s;

  rrc_state_s r;
  rrc_state_s next_r;

  // one-hot prime for a target pattern, zero when not a target
  function automatic logic [3:0] tgt_decode(input logic [3:0] pat);
    case (pat)
      rrc_pkg::PAT_TGT1: tgt_decode = 4'h1;
      rrc_pkg::PAT_TGT2: tgt_decode = 4'h2;
      rrc_pkg::PAT_TGT3: tgt_decode = 4'h4;
      rrc_pkg::PAT_TGT4: tgt_decode = 4'h8;
      default: tgt_decode = 4'h0;
    endcase
  endfunction

  logic [3:0] lines;
  logic [3:0] new_pat;
  logic new_word;
  logic wb_req;
  logic kick;
  logic [31:0] status;

  // pulled-up lines read high when open
  assign lines = {cmd_input_bit3_i, cmd_input_bit2_i, cmd_input_bit1_i, cmd_input_bit0_i};
  assign new_pat = r.s3 ^ r.acc;
  assign new_word = r.word_ev && (r.word_pat != r.last_pat);
  assign wb_req = wb_cyc_i && wb_stb_i && !r.ack;
  assign kick = wb_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == rrc_pkg::OFS_CTRL)
    && wb_dat_i[rrc_pkg::CT_KICK];

  always_comb begin
    status = 32'h0;
    status[rrc_pkg::ST_REMOTE] = r.remote;
    status[rrc_pkg::ST_SEQ +: 2] = r.seq;
    status[rrc_pkg::ST_LINES +: 4] = r.acc;
    status[rrc_pkg::ST_MOD +: 4] = r.mod_on;
    status[rrc_pkg::ST_DMD +: 4] = r.dmd_on;
    status[rrc_pkg::ST_LAST +: 4] = r.last_pat;
    status[rrc_pkg::ST_CTRL_OK] = (r.wd_cnt != '0);
  end

  always_comb begin
    next_r = r;
    next_r.s1 = lines;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    next_r.word_ev = 1'b0;
    // debounce: a change counts once the second and third stages agree and hold it for DEBOUNCE_CYC cycles
    if (r.s2 != r.s3 || r.s3 == r.acc) begin
      next_r.deb_cnt = '0;
      next_r.pend = r.acc;
    end else if (r.s3 != r.pend) begin
      next_r.deb_cnt = '0;
      next_r.pend = r.s3;
    end else if (r.deb_cnt == DEB_LAST) begin
      next_r.deb_cnt = '0;
      next_r.acc = r.pend;
      next_r.word_ev = 1'b1;
      next_r.word_pat = new_pat;
    end else begin
      next_r.deb_cnt = r.deb_cnt + 1'b1;
    end
    // gap timer between words
    if (r.seq == rrc_pkg::SQ_IDLE || new_word) begin
      next_r.gap_cnt = '0;
    end else begin
      next_r.gap_cnt = r.gap_cnt + 1'b1;
    end
    if (new_word) begin
      // RZ return repeats the pattern and is dropped by the repeat check
      next_r.last_pat = r.word_pat;
      if (r.word_pat == rrc_pkg::PAT_START) begin
        next_r.seq = rrc_pkg::SQ_CMD;
      end else begin
        next_r.seq = rrc_pkg::SQ_IDLE;
        case (r.seq)
          rrc_pkg::SQ_CMD: begin
            case (r.word_pat)
              rrc_pkg::PAT_AUTO: begin
                next_r.cmd = rrc_pkg::CM_AUTO;
                next_r.seq = rrc_pkg::SQ_EXE;
              end
              rrc_pkg::PAT_REMOTE: begin
                next_r.cmd = rrc_pkg::CM_REMOTE;
                next_r.seq = rrc_pkg::SQ_EXE;
              end
              rrc_pkg::PAT_BMOD: begin
                next_r.cmd = rrc_pkg::CM_BMOD;
                next_r.seq = rrc_pkg::SQ_TGT;
              end
              rrc_pkg::PAT_BDEMOD: begin
                next_r.cmd = rrc_pkg::CM_BDEMOD;
                next_r.seq = rrc_pkg::SQ_TGT;
              end
              default: next_r.seq = rrc_pkg::SQ_IDLE;
            endcase
          end
          rrc_pkg::SQ_TGT: begin
            if (r.word_pat == rrc_pkg::PAT_EXEC) begin
              next_r.exec_cnt = r.exec_cnt + 1'b1;
              if (r.remote && r.cmd == rrc_pkg::CM_BMOD) begin
                next_r.mod_on = 4'h0;
              end
              if (r.remote && r.cmd == rrc_pkg::CM_BDEMOD) begin
                next_r.dmd_on = 4'h0;
              end
            end else if (tgt_decode(r.word_pat) != 4'h0) begin
              next_r.tgt = tgt_decode(r.word_pat);
              next_r.seq = rrc_pkg::SQ_EXE;
            end
          end
          rrc_pkg::SQ_EXE: begin
            if (r.word_pat == rrc_pkg::PAT_EXEC) begin
              next_r.exec_cnt = r.exec_cnt + 1'b1;
              case (r.cmd)
                rrc_pkg::CM_REMOTE: next_r.remote = 1'b1;
                rrc_pkg::CM_AUTO: next_r.remote = 1'b0;
                rrc_pkg::CM_BMOD: begin
                  if (r.remote) begin
                    next_r.mod_on = r.tgt;
                  end
                end
                default: begin
                  if (r.remote) begin
                    next_r.dmd_on = r.tgt;
                  end
                end
              endcase
            end
          end
          default: next_r.seq = rrc_pkg::SQ_IDLE;
        endcase
      end
    end else if (r.seq != rrc_pkg::SQ_IDLE && r.gap_cnt == GAP_LAST) begin
      next_r.seq = rrc_pkg::SQ_IDLE;
      next_r.last_pat = 4'h0;
    end
    // controller monostable, retriggered by software
    if (kick) begin
      next_r.wd_cnt = WD_LOAD;
    end else if (r.wd_cnt != '0) begin
      next_r.wd_cnt = r.wd_cnt - 1'b1;
    end
    next_r.sys_rel = backup_fail_i || comm_fail_i || config_fail_i || setup_fail_i;
    next_r.dsf_rel = (dmd_active_i != 4'h0)
      && ((dmd_carrier_loss_i & dmd_active_i) == dmd_active_i);
    // wishbone slave, one wait state
    next_r.ack = wb_req;
    next_r.rdat = 32'h0;
    if (wb_req && !wb_we_i) begin
      case (wb_adr_i)
        rrc_pkg::OFS_STATUS: next_r.rdat = status;
        rrc_pkg::OFS_COUNT: next_r.rdat = {24'h0, r.exec_cnt};
        default: next_r.rdat = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
      r.s1 <= rrc_pkg::LINES_IDLE;
      r.s2 <= rrc_pkg::LINES_IDLE;
      r.s3 <= rrc_pkg::LINES_IDLE;
      r.acc <= rrc_pkg::LINES_IDLE;
      r.pend <= rrc_pkg::LINES_IDLE;
    end else begin
      r <= next_r;
    end
  end

  assign wb_ack_o = r.ack;
  assign wb_dat_o = r.rdat;
  assign ctrl_fault_relay_o = (r.wd_cnt != '0);
  assign sys_fault_relay_o = r.sys_rel;
  assign dmd_sig_fault_relay_o = r.dsf_rel;
  assign mod_online_relay_o = r.mod_on;
  assign dmd_online_relay_o = r.dmd_on;
  assign remote_mode_o = r.remote;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  word_debounce_a: assert property (r.word_ev |-> $past(r.deb_cnt) == DEB_LAST
    && r.acc == $past(r.pend) && r.word_pat == (r.acc ^ $past(r.acc)))
    else $error("word taken without full debounce");
  repeat_drop_a: assert property (r.word_ev && r.word_pat == r.last_pat
    && r.gap_cnt != GAP_LAST
    |=> r.seq == $past(r.seq) && $stable(r.remote) && $stable(r.mod_on))
    else $error("repeated word acted on");
  start_restart_a: assert property (new_word && r.word_pat == rrc_pkg::PAT_START
    |=> r.seq == rrc_pkg::SQ_CMD)
    else $error("start word did not restart sequence");
  gap_clear_a: assert property (r.seq != rrc_pkg::SQ_IDLE && r.gap_cnt == GAP_LAST
    && !new_word |=> r.seq == rrc_pkg::SQ_IDLE && r.last_pat == 4'h0)
    else $error("word gap timeout missed");
  remote_entry_a: assert property ($rose(r.remote) |-> $past(r.seq) == rrc_pkg::SQ_EXE
    && $past(r.cmd) == rrc_pkg::CM_REMOTE && $past(r.word_pat) == rrc_pkg::PAT_EXEC)
    else $error("remote mode entered without command");
  auto_gate_a: assert property ($fell(r.remote) |-> $past(r.cmd) == rrc_pkg::CM_AUTO
    && $past(new_word) && $past(r.word_pat) == rrc_pkg::PAT_EXEC)
    else $error("auto mode entered wrongly");
  mod_change_a: assert property (!$stable(r.mod_on) |-> $past(r.remote)
    && $past(r.cmd) == rrc_pkg::CM_BMOD && $onehot0(r.mod_on))
    else $error("backup modulator changed outside remote");
  dmd_change_a: assert property (!$stable(r.dmd_on) |-> $past(r.remote)
    && $past(r.cmd) == rrc_pkg::CM_BDEMOD && $onehot0(r.dmd_on))
    else $error("backup demodulator changed outside remote");
  wd_hold_a: assert property (kick |=> ctrl_fault_relay_o ##1 ctrl_fault_relay_o)
    else $error("controller relay not held after retrigger");
  sys_fault_a: assert property ((backup_fail_i || comm_fail_i || config_fail_i
    || setup_fail_i) |=> sys_fault_relay_o)
    else $error("system fault relay not energized");
  sys_quiet_a: assert property (!(backup_fail_i || comm_fail_i || config_fail_i
    || setup_fail_i) |=> !sys_fault_relay_o)
    else $error("system fault relay energized without failure");
  dsf_relay_a: assert property (dmd_active_i == 4'h0 |=> !dmd_sig_fault_relay_o)
    else $error("demod fault relay with no active demod");
  dsf_loss_a: assert property (dmd_active_i != 4'h0
    && (dmd_carrier_loss_i & dmd_active_i) == dmd_active_i |=> dmd_sig_fault_relay_o)
    else $error("demod fault relay not energized on total loss");
  wd_drop_a: assert property (r.wd_cnt == CW'(1) && !kick
    |=> !ctrl_fault_relay_o)
    else $error("controller relay held without retrigger");
  order_idle_a: assert property (new_word && r.seq == rrc_pkg::SQ_IDLE
    && r.word_pat != rrc_pkg::PAT_START |=> r.seq == rrc_pkg::SQ_IDLE)
    else $error("word accepted before start");
  target_bcd_a: assert property (new_word && r.seq == rrc_pkg::SQ_TGT
    && r.word_pat == rrc_pkg::PAT_TGT3 |=> r.tgt == 4'h4 && r.seq == rrc_pkg::SQ_EXE)
    else $error("target word decoded wrongly");
  exec_count_a: assert property ($changed(r.exec_cnt) |-> $past(new_word)
    && $past(r.word_pat) == rrc_pkg::PAT_EXEC
    && $past(r.seq) inside {rrc_pkg::SQ_TGT, rrc_pkg::SQ_EXE})
    else $error("execute counted outside a sequence");
  mod_target_a: assert property (new_word && r.seq == rrc_pkg::SQ_EXE && r.remote
    && r.cmd == rrc_pkg::CM_BMOD && r.word_pat == rrc_pkg::PAT_EXEC
    |=> mod_online_relay_o == $past(r.tgt))
    else $error("backup modulator not placed online");
  wb_ack_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  remote_cmd_c: cover property ($rose(r.remote));
  auto_cmd_c: cover property ($fell(r.remote));
  mod_online_c: cover property ($rose(r.mod_on != 4'h0));
  gap_timeout_c: cover property (r.seq != rrc_pkg::SQ_IDLE && r.gap_cnt == GAP_LAST);
  offline_cmd_c: cover property (new_word && r.seq == rrc_pkg::SQ_TGT
    && r.word_pat == rrc_pkg::PAT_EXEC);
endmodule
`default_nettype wire

// ---- sim/rrc_sender.sv ----
// contact-closure sender model for the four relay-remote lines
`timescale 1ns/10ps
`default_nettype none
module rrc_sender (
  input wire logic clk_i,
  output var logic [3:0] lines_o
);
  // open contacts read high through the pull-ups
  initial lines_o = 4'hf;
  // flip the lines in p, hold them, return them in rz signalling, then pause
  task automatic send(input logic [3:0] p, input int hold, input logic rz, input int gap);
    @(posedge clk_i);
    lines_o <= lines_o ^ p;
    repeat (hold) @(posedge clk_i);
    if (rz) begin
      lines_o <= lines_o ^ p;
    end
    repeat (gap) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// ---- sim/tb_top.sv ----
// self-checking bench for the relay-remote command decoder
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam int DEB = 8;
  localparam int GAP = 200;
  localparam int WD = 50;
  localparam logic [3:0] S = rrc_pkg::PAT_START;
  localparam logic [3:0] E = rrc_pkg::PAT_EXEC;
  localparam logic [3:0] RM = rrc_pkg::PAT_REMOTE;
  localparam logic [3:0] AU = rrc_pkg::PAT_AUTO;
  localparam logic [3:0] BM = rrc_pkg::PAT_BMOD;
  localparam logic [3:0] BD = rrc_pkg::PAT_BDEMOD;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] lines;
  logic [3:0] fail = 4'h0;
  logic [3:0] dact = 4'h0;
  logic [3:0] dloss = 4'h0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic ack;
  logic ctrl_rly;
  logic sys_rly;
  logic dsig_rly;
  logic remote;
  logic [3:0] mod_on;
  logic [3:0] dmd_on;
  int n_mismatch = 0;
  int tests_run = 0;
  always #20 clk_i = ~clk_i;
  rrc_sender i_rrc_sender (.clk_i(clk_i), .lines_o(lines));
  rrc_decoder #(.DEBOUNCE_CYC(DEB), .GAP_CYC(GAP), .WD_CYC(WD)) i_rrc_decoder (
    .clk_i(clk_i), .rst_i(rst_i),
    .cmd_input_bit3_i(lines[3]), .cmd_input_bit2_i(lines[2]),
    .cmd_input_bit1_i(lines[1]), .cmd_input_bit0_i(lines[0]),
    .backup_fail_i(fail[0]), .comm_fail_i(fail[1]),
    .config_fail_i(fail[2]), .setup_fail_i(fail[3]),
    .dmd_active_i(dact), .dmd_carrier_loss_i(dloss),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .ctrl_fault_relay_o(ctrl_rly), .sys_fault_relay_o(sys_rly),
    .dmd_sig_fault_relay_o(dsig_rly), .mod_online_relay_o(mod_on),
    .dmd_online_relay_o(dmd_on), .remote_mode_o(remote));
  task automatic give_verdict;
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one classic wishbone cycle; read data lands in q
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      n_mismatch++;
      give_verdict();
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  // send the first n words of ws, leftmost first
  task automatic cmd(input logic [19:0] ws, input int n, input logic rz);
    for (int i = 0; i < n; i++) begin
      i_rrc_sender.send(ws[19-4*i -: 4], 20, rz, 40);
    end
    @(negedge clk_i);
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk("relays", {ctrl_rly, sys_rly, dsig_rly, remote, mod_on, dmd_on}, 12'h0);
    wb(1'b0, rrc_pkg::OFS_STATUS, 32'h0);
    chk("status", q[7:0], 8'hf0);
    cmd({S, BM, 4'h2, E, 4'h0}, 4, 1'b0);
    chk("gated", {remote, mod_on, dmd_on}, 9'h0);
    cmd({S, RM, 12'h0}, 2, 1'b0);
    fork
      i_rrc_sender.send(E, 20, 1'b0, 40);
      begin
        // 3 sync edges, DEB counts and one edge to the word, one more to the mode
        repeat (DEB + 5) @(posedge clk_i);
        @(negedge clk_i);
        chk("early", remote, 1'b0);
        @(posedge clk_i);
        @(negedge clk_i);
        chk("remote", remote, 1'b1);
      end
    join
    wb(1'b0, rrc_pkg::OFS_COUNT, 32'h0);
    chk("count", q, 32'h2);
    cmd({S, BM, BM, 4'h1, E}, 5, 1'b0);
    chk("repeat", mod_on, 4'h1);
    for (int t = 1; t <= 4; t++) begin
      cmd({S, BD, t[3:0], E, 4'h0}, 4, t[0]);
      chk("target", dmd_on, 4'h1 << (t - 1));
    end
    cmd({S, BM, E, 8'h0}, 3, 1'b0);
    chk("offline", {mod_on, dmd_on}, 8'h08);
    cmd({S, BD, 4'h5, E, 4'h0}, 4, 1'b0);
    chk("invalid", dmd_on, 4'h8);
    cmd({S, BM, S, BM, 4'h3}, 5, 1'b0);
    cmd({E, 16'h0}, 1, 1'b0);
    chk("restart", mod_on, 4'h4);
    cmd({S, BD, 12'h0}, 2, 1'b0);
    repeat (GAP + 20) @(posedge clk_i);
    cmd({4'h2, E, 12'h0}, 2, 1'b0);
    chk("gap", dmd_on, 4'h8);
    i_rrc_sender.send(BM, 3, 1'b1, 40);
    wb(1'b0, rrc_pkg::OFS_STATUS, 32'h0);
    chk("glitch", {q[19:16], q[7:4], q[0]}, {E, lines, 1'b1});
    cmd({S, AU, E, 8'h0}, 3, 1'b0);
    chk("auto", {remote, mod_on}, 5'h04);
    cmd({S, BM, 4'h1, E, 4'h0}, 4, 1'b0);
    chk("auto gated", mod_on, 4'h4);
    for (int i = 0; i < 6; i++) begin
      @(posedge clk_i);
      fail <= (i < 4) ? 4'h1 << i : 4'h0;
      dact <= (i == 5) ? 4'h0 : 4'h5;
      dloss <= (i == 4) ? 4'h5 : 4'h1;
      repeat (3) @(negedge clk_i);
      chk("faults", {sys_rly, dsig_rly}, {i < 4, i == 4});
    end
    chk("ctrl", ctrl_rly, 1'b0);
    for (int i = 0; i < 2; i++) begin
      wb(1'b1, rrc_pkg::OFS_CTRL, 32'h1);
      repeat (WD - 10) @(negedge clk_i);
      chk("held", ctrl_rly, 1'b1);
    end
    repeat (20) @(negedge clk_i);
    chk("dropped", ctrl_rly, 1'b0);
    wb(1'b0, 8'hfc, 32'h0);
    chk("unmapped", q, 32'h0);
    give_verdict();
  end
endmodule
`default_nettype wire
